// file: include/rtmr_pkg.sv
// Package of constants and carrier types for the reload timer
`default_nettype none
package rtmr_pkg;
	// Register offsets
	localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h0B;
	localparam logic [7:0] OFS_IRQ_FLAG     = 8'h0C;
	localparam logic [7:0] OFS_COUNT        = 8'h12;
	localparam logic [7:0] OFS_RELOAD       = 8'h13;
	localparam logic [7:0] OFS_PRESCALE     = 8'h14;
	localparam logic [7:0] OFS_MISC_CTRL    = 8'h16;
	localparam logic [7:0] OFS_OUT_ENABLE   = 8'h98;
	// Field positions
	localparam int         BIT_TIMER_IRQ    = 5;
	localparam int         BIT_COUNT_STOP   = 4;
	localparam int         BIT_TOGGLE_OE    = 6;
	localparam int         PSC_W            = 4;
	// Reset values
	localparam logic [7:0] RST_BYTE         = 8'h00;
	localparam logic [PSC_W-1:0] RST_PSC    = 4'h0;
	// Prescaler chain width: divide by up to 512 of the system clock
	localparam int         DIV_W            = 9;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rtmr_req_t;

	// Prescaler code to the index of the chain bit whose carry ticks
	function automatic logic [3:0] rtmr_tap(input logic [PSC_W-1:0] code);
		rtmr_tap = code[3] ? 4'h8 : {1'b0, code[2:0]};
	endfunction
endpackage
`default_nettype wire

// file: logic/rtmr_prescaler.sv
// Power-of-two prescaler producing one-cycle tick enables
`default_nettype none
module rtmr_prescaler (
	input  wire logic                       clock,
	input  wire logic                       sys_rst,
	input  wire logic                       clear,
	input  wire logic [rtmr_pkg::PSC_W-1:0] code,
	output logic                            tick
);
	logic [rtmr_pkg::DIV_W-1:0] div_r;
	logic [3:0]                 tap;

	// Free divider; cleared when counter or prescaler is written
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			div_r <= '0;
		end else if (clear) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 9'h001;
		end
	end

	// Tick when all bits up to the tap are ones: divide by 2^(tap+1)
	always_comb begin
		tap  = rtmr_pkg::rtmr_tap(code);
		tick = 1'b1;
		for (int i = 0; i < rtmr_pkg::DIV_W; i++) begin
			if (i <= int'(tap) && !div_r[i]) begin
				tick = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: logic/rtmr_irq.sv
// Sticky timer event flag with enable gating
`default_nettype none
module rtmr_irq (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic event_set,
	input  wire logic flag_wr,
	input  wire logic flag_wdata,
	input  wire logic enable,
	output logic      pending,
	output logic      irq
);
	logic pending_r;

	// Set wins over a software clear in the same cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pending_r <= 1'b0;
		end else if (event_set) begin
			pending_r <= 1'b1;
		end else if (flag_wr && !flag_wdata) begin
			pending_r <= 1'b0;
		end
	end

	assign pending = pending_r;
	assign irq     = pending_r & enable;
endmodule
`default_nettype wire

// file: logic/rtmr_timer.sv
// Eight-bit auto-reload interval timer with toggle output and register port
//
// Added by the designer: the address-and-strobe port.
`default_nettype none
// Register map, byte offsets on the register port
//   0x0B  interrupt enable byte; bit 5 gates the timer request
//   0x0C  interrupt flag byte; bit 5 is the sticky timer pending flag
//   0x12  timer count; read and write at any time
//   0x13  reload value; write-only, reads back zero
//   0x14  prescaler control; low four bits hold the code, write-only
//   0x16  miscellaneous control; bit 4 stops counting
//   0x98  output enable byte; bit 6 routes the toggle to the pin
// Timing summary
//   A tick comes every 2^(code+1) clocks, or every 512 clocks with code bit 3 set
//   A count write or prescaler write restarts the divider, so the next tick is whole
//   A count write in a tick cycle wins; that tick is lost
//   Overflow reloads, sets the pending flag and flips the toggle on one edge
//   Flag clear and overflow in one cycle: the flag stays set
//   Read data stand for one cycle after the read strobe, zero otherwise
// Usage hazards
//   Writing the count restarts the prescaler, so frequent writes stretch the period
//   The toggle level survives disabling the pin; it reappears when re-enabled
module rtmr_timer (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	output logic            toggle_pin_out,
	output logic            toggle_pin_oe,
	output logic            irq
);
	rtmr_pkg::rtmr_req_t      req;
	logic [7:0]               timer_count_r;
	logic [7:0]               reload_value_r;
	logic [rtmr_pkg::PSC_W-1:0] prescale_code_r;
	logic [7:0]               irq_enable_r;
	logic [7:0]               misc_ctrl_r;
	logic [7:0]               out_enable_r;
	logic                     overflow_toggle_out_r;
	logic [7:0]               rdata_r;
	logic                     wr_count;
	logic                     wr_psc;
	logic                     wr_flag;
	logic                     tick;
	logic                     count_stop;
	logic                     step;
	logic                     overflow;
	logic                     pending;

	// Bundle the register port
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// Write decode
	always_comb begin
		wr_count = 1'b0;
		wr_psc   = 1'b0;
		wr_flag  = 1'b0;
		if (req.wr && req.addr == rtmr_pkg::OFS_COUNT) begin
			wr_count = 1'b1;
		end else if (req.wr && req.addr == rtmr_pkg::OFS_PRESCALE) begin
			wr_psc = 1'b1;
		end else if (req.wr && req.addr == rtmr_pkg::OFS_IRQ_FLAG) begin
			wr_flag = 1'b1;
		end
	end

	// Control registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			reload_value_r  <= rtmr_pkg::RST_BYTE;
			prescale_code_r <= rtmr_pkg::RST_PSC;
			irq_enable_r    <= rtmr_pkg::RST_BYTE;
			misc_ctrl_r     <= rtmr_pkg::RST_BYTE;
			out_enable_r    <= rtmr_pkg::RST_BYTE;
		end else if (req.wr) begin
			if (req.addr == rtmr_pkg::OFS_RELOAD) begin
				reload_value_r <= req.wdata;
			end else if (req.addr == rtmr_pkg::OFS_PRESCALE) begin
				prescale_code_r <= req.wdata[rtmr_pkg::PSC_W-1:0];
			end else if (req.addr == rtmr_pkg::OFS_IRQ_ENABLE) begin
				irq_enable_r <= req.wdata;
			end else if (req.addr == rtmr_pkg::OFS_MISC_CTRL) begin
				misc_ctrl_r <= req.wdata;
			end else if (req.addr == rtmr_pkg::OFS_OUT_ENABLE) begin
				out_enable_r <= req.wdata;
			end
		end
	end

	// Prescaler restarts on counter or prescaler writes so the first period is whole
	rtmr_prescaler u_psc (
		.clock   (clock),
		.sys_rst (sys_rst),
		.clear   (wr_count | wr_psc),
		.code    (prescale_code_r),
		.tick    (tick)
	);

	assign count_stop = misc_ctrl_r[rtmr_pkg::BIT_COUNT_STOP];
	assign step       = tick & ~count_stop & ~wr_count;
	assign overflow   = step & (timer_count_r == 8'hFF);

	// Counter: software write wins, else step or reload
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			timer_count_r <= rtmr_pkg::RST_BYTE;
		end else if (wr_count) begin
			timer_count_r <= req.wdata;
		end else if (overflow) begin
			timer_count_r <= reload_value_r;
		end else if (step) begin
			timer_count_r <= timer_count_r + 8'h01;
		end
	end

	// Toggle output flips on each overflow
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			overflow_toggle_out_r <= 1'b0;
		end else if (overflow) begin
			overflow_toggle_out_r <= ~overflow_toggle_out_r;
		end
	end

	// Pin routing gated by the output enable bit
	assign toggle_pin_oe  = out_enable_r[rtmr_pkg::BIT_TOGGLE_OE];
	assign toggle_pin_out = overflow_toggle_out_r & toggle_pin_oe;

	// Pending flag and interrupt request
	rtmr_irq u_irq (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.event_set  (overflow),
		.flag_wr    (wr_flag),
		.flag_wdata (req.wdata[rtmr_pkg::BIT_TIMER_IRQ]),
		.enable     (irq_enable_r[rtmr_pkg::BIT_TIMER_IRQ]),
		.pending    (pending),
		.irq        (irq)
	);

	// Read data one cycle after the strobe; write-only and unmapped read zero
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= rtmr_pkg::RST_BYTE;
		end else if (req.rd) begin
			if (req.addr == rtmr_pkg::OFS_COUNT) begin
				rdata_r <= timer_count_r;
			end else if (req.addr == rtmr_pkg::OFS_IRQ_FLAG) begin
				rdata_r <= 8'(pending) << rtmr_pkg::BIT_TIMER_IRQ;
			end else if (req.addr == rtmr_pkg::OFS_IRQ_ENABLE) begin
				rdata_r <= irq_enable_r;
			end else if (req.addr == rtmr_pkg::OFS_MISC_CTRL) begin
				rdata_r <= misc_ctrl_r;
			end else if (req.addr == rtmr_pkg::OFS_OUT_ENABLE) begin
				rdata_r <= out_enable_r;
			end else begin
				rdata_r <= rtmr_pkg::RST_BYTE;
			end
		end else begin
			rdata_r <= rtmr_pkg::RST_BYTE;
		end
	end

	assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// file: sim/rtmr_monitor.sv
// Port checker for the reload timer
`default_nettype none
module rtmr_monitor (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       toggle_pin_out,
	input wire logic       toggle_pin_oe,
	input wire logic       irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic en_r;
	logic stop_r;
	// Shadow of the enable and stop bits seen on the bus
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			en_r <= 1'h0;
			stop_r <= 1'h0;
		end else if (reg_wr) begin
			if (reg_addr == rtmr_pkg::OFS_IRQ_ENABLE) en_r <= reg_wdata[5];
			if (reg_addr == rtmr_pkg::OFS_MISC_CTRL) stop_r <= reg_wdata[4];
		end
	end
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
	a_wo_zero: assert property (reg_rd && reg_addr inside {8'h13, 8'h14} |=> reg_rdata == 8'h00)
		else $error("write-only register read back");
	a_oe_follow: assert property (reg_wr && reg_addr == 8'h98 |=> toggle_pin_oe == $past(reg_wdata[6]))
		else $error("pin enable wrong");
	a_pin_gated: assert property (!toggle_pin_oe |-> !toggle_pin_out) else $error("pin driven while off");
	a_stop_hold: assert property (stop_r && $past(stop_r) && !$past(reg_wr) |-> $stable(toggle_pin_out))
		else $error("toggled while stopped");
	a_toggle_flag: assert property ($changed(toggle_pin_out) && $stable(toggle_pin_oe) && en_r |-> irq)
		else $error("overflow without request");
	a_irq_mask: assert property (reg_wr && reg_addr == 8'h0B && !reg_wdata[5] |=> !irq)
		else $error("masked request seen");
	a_flag_sticky: assert property (irq && !reg_wr |=> irq) else $error("request dropped alone");
	c_irq: cover property ($rose(irq));
	c_toggle: cover property ($changed(toggle_pin_out));
	c_stop: cover property (stop_r && reg_rd);
endmodule
bind rtmr_timer rtmr_monitor i_rtmr_monitor (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.toggle_pin_out(toggle_pin_out), .toggle_pin_oe(toggle_pin_oe), .irq(irq));
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the reload timer
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock = 1'h0;
	logic       sys_rst = 1'h1;
	logic       reg_wr = 1'h0;
	logic       reg_rd = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata, d, r;
	logic       toggle_pin_out, toggle_pin_oe, irq;
	int         n_errors = 0;
	int         n_compared = 0;
	int         n;
	rtmr_timer i_rtmr_timer (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .toggle_pin_out(toggle_pin_out),
		.toggle_pin_oe(toggle_pin_oe), .irq(irq));
	// System clock
	initial begin
		forever #10 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'h0;
		@(negedge clock);
		v = reg_rdata;
	endtask
	// Clocks until the toggle pin next changes
	task automatic tgl(output int c);
		logic p;
		p = toggle_pin_out;
		c = 0;
		do begin
			@(negedge clock);
			c++;
		end while (toggle_pin_out === p && c < 9000);
	endtask
	// Expected overflow period in clocks: prescaled ticks per rollover times clocks per tick
	function automatic int exp_period(input logic [3:0] code, input logic [7:0] rld);
		int div;
		div = code[3] ? 512 : (2 << code[2:0]);
		return (256 - int'(rld)) * div;
	endfunction
	task automatic results;
		if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		#1000000;
		n_errors++;
		results();
	end
	// Main sequence
	initial begin
		void'($urandom(88725));
		repeat (6) @(posedge clock);
		sys_rst <= 1'h0;
		for (int i = 0; i < 7; i++) begin
			rd(8'({8'h0B, 8'h0C, 8'h13, 8'h14, 8'h16, 8'h98, 8'h55} >> (8 * (6 - i))), d);
			chk("reset value", 8'h00, d);
		end
		wr(8'h16, 8'h10);
		r = 8'($urandom);
		wr(8'h12, r);
		rd(8'h12, d);
		chk("count", r, d);
		repeat (20) @(posedge clock);
		rd(8'h12, d);
		chk("held count", r, d);
		wr(8'h12, 8'hFF);
		wr(8'h16, 8'h00);
		repeat (4) @(posedge clock);
		wr(8'h16, 8'h10);
		rd(8'h0C, d);
		chk("flag", 8'h20, d);
		chk("masked irq", 1'h0, irq);
		wr(8'h0B, 8'h20);
		@(negedge clock);
		chk("irq", 1'h1, irq);
		wr(8'h0C, 8'hFF);
		@(negedge clock);
		chk("irq kept", 1'h1, irq);
		wr(8'h0C, 8'h00);
		@(negedge clock);
		chk("irq cleared", 1'h0, irq);
		wr(8'h98, 8'h40);
		wr(8'h16, 8'h00);
		// Overflow period for codes 0 to 7 and one random code from 8 to 15, reload FFh as corner
		for (int k = 0; k < 9; k++) begin
			r = (k == 0) ? 8'hFF : 8'hF8 + 8'($urandom % 7);
			d = (k == 8) ? 8'h08 + 8'($urandom % 8) : 8'(k);
			wr(8'h13, r);
			wr(8'h14, d);
			wr(8'h12, 8'hFF);
			@(negedge clock);
			tgl(n);
			tgl(n);
			chk("period", 16'(exp_period(d[3:0], r)), 16'(n));
			chk("irq set", 1'h1, irq);
		end
		chk("pin enable", 1'h1, toggle_pin_oe);
		wr(8'h98, 8'h00);
		@(negedge clock);
		chk("pin off", 1'h0, toggle_pin_out);
		results();
	end
endmodule
`default_nettype wire
